/* verilog/mcfb_pkg.sv */
// Register map, field layout and reset values of the clock and frequency bank
package mcfb_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_CLOCK_A    = 8'h07;
    localparam logic [7:0] ADDR_FREQ_WORD_SET_B_HI  = 8'h08;
    localparam logic [7:0] ADDR_FREQ_WORD_SET_B_MID = 8'h09;
    localparam logic [7:0] ADDR_FREQ_WORD_SET_B_LO  = 8'h0a;
    localparam logic [7:0] ADDR_CLOCK_B    = 8'h0b;
    localparam logic [7:0] ADDR_OSC_CUR    = 8'h0c;
    localparam logic [7:0] ADDR_MODEM      = 8'h0d;
    localparam logic [7:0] ADDR_MAIN_CTRL  = 8'h0e;
    // Reset values
    localparam logic [7:0] RST_CLOCK       = 8'h50;
    localparam logic [7:0] RST_FREQ_WORD_SET_B_HI   = 8'h83;
    localparam logic [7:0] RST_FREQ_WORD_SET_B_MID  = 8'hbd;
    localparam logic [7:0] RST_FREQ_WORD_SET_B_LO   = 8'hf9;
    localparam logic [7:0] RST_OSC_CUR     = 8'h88;
    localparam logic [7:0] RST_MODEM       = 8'h00;
    localparam logic [7:0] RST_MAIN_CTRL   = 8'h01;
    // Field positions
    localparam int REF_DIV_LSB   = 5;
    localparam int DIV1_LSB      = 2;
    localparam int CUR_A_LSB     = 4;
    localparam int SCRAMBLE_BIT  = 2;
    localparam int MAIN_SEL_BIT  = 6;
    localparam int MAIN_RSTN_BIT = 0;
    // Writable bits of the modem control register; spare bits read zero
    localparam logic [7:0] MODEM_WMASK = 8'h07;
    // Divide ratios in half steps, so 2.5 becomes 5
    localparam logic [7:0] HALF_DIV1 [8] = '{8'h05, 8'h06, 8'h08, 8'h0f,
                                             8'h19, 8'h50, 8'h60, 8'h80};
    // Data format codes
    localparam logic [1:0] FMT_NRZ   = 2'h0;
    localparam logic [1:0] FMT_MANCH = 2'h1;
    localparam logic [1:0] FMT_UART0 = 2'h2;
    localparam logic [1:0] FMT_UART1 = 2'h3;
    // Scrambler feedback taps for x^9 + x^5 + 1
    localparam int PN_LEN = 9;
    localparam int PN_TAP = 5;
    localparam logic [8:0] PN_SEED = 9'h1ff;
    // Baud is the modem clock divided by this
    localparam int BAUD_DIV = 8;
endpackage

/* verilog/mcfb_bank.sv */
// Clock divider, frequency word B and modem control register bank
`timescale 1ns/1ps
`default_nettype none
module mcfb_bank
    import mcfb_pkg::*;
#(
    parameter int ACC_W = 12
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // Set A frequency word from the neighbouring bank
    input  wire logic [22:0] freq_word_set_a,
    input  wire logic        dither_enable_set_a,
    // Transmit data in and out
    input  wire logic        tx_bit,
    output logic             tx_data,
    // Active settings, plus the oscillator currents of both sets
    output logic [22:0]      freq_word_active,
    output logic             dither_active,
    output logic [3:0]       osc_core_current,
    output logic [3:0]       osc_core_current_set_a,
    output logic [3:0]       osc_core_current_set_b,
    // Derived clocks: one-cycle enables on clk, plus the data clock level
    output logic             reference_frequency,
    output logic             modem_clk_en,
    output logic             baud_en,
    output logic             data_clock_out
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] clk_a, clk_b, fb_hi, fb_mid, fb_lo, osc_cur, modem, main_ctrl;
    logic       soft_rst;

    // Control register is outside the soft reset by design
    always_ff @(posedge clk) begin
        if (!nrst) begin
            main_ctrl <= RST_MAIN_CTRL;
        end else if (wr && addr == ADDR_MAIN_CTRL) begin
            main_ctrl <= wdata;
        end
    end
    assign soft_rst = !main_ctrl[MAIN_RSTN_BIT];

    // Bank registers; soft reset wins over a write
    always_ff @(posedge clk) begin
        if (!nrst || soft_rst) begin
            clk_a   <= RST_CLOCK;
            clk_b   <= RST_CLOCK;
            fb_hi   <= RST_FREQ_WORD_SET_B_HI;
            fb_mid  <= RST_FREQ_WORD_SET_B_MID;
            fb_lo   <= RST_FREQ_WORD_SET_B_LO;
            osc_cur <= RST_OSC_CUR;
            modem   <= RST_MODEM;
        end else if (wr) begin
            case (addr)
                ADDR_CLOCK_A:    clk_a   <= wdata;
                ADDR_FREQ_WORD_SET_B_HI:  fb_hi   <= wdata;
                ADDR_FREQ_WORD_SET_B_MID: fb_mid  <= wdata;
                ADDR_FREQ_WORD_SET_B_LO:  fb_lo   <= wdata;
                ADDR_CLOCK_B:    clk_b   <= wdata;
                ADDR_OSC_CUR:    osc_cur <= wdata;
                ADDR_MODEM:      modem   <= wdata & MODEM_WMASK;
                default:         ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                ADDR_CLOCK_A:    rdata <= clk_a;
                ADDR_FREQ_WORD_SET_B_HI:  rdata <= fb_hi;
                ADDR_FREQ_WORD_SET_B_MID: rdata <= fb_mid;
                ADDR_FREQ_WORD_SET_B_LO:  rdata <= fb_lo;
                ADDR_CLOCK_B:    rdata <= clk_b;
                ADDR_OSC_CUR:    rdata <= osc_cur;
                ADDR_MODEM:      rdata <= modem;
                ADDR_MAIN_CTRL:  rdata <= main_ctrl;
                default:         rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Set selection
    // ----------------------------------------------------------------
    logic       sel_b;
    logic [7:0] clk_act;
    assign sel_b   = main_ctrl[MAIN_SEL_BIT];
    assign clk_act = sel_b ? clk_b : clk_a;

    always_comb begin
        freq_word_active = sel_b ? {fb_hi, fb_mid, fb_lo[7:1]} : freq_word_set_a;
        dither_active    = sel_b ? fb_lo[0] : dither_enable_set_a;
    end

    assign osc_core_current_set_a = osc_cur[CUR_A_LSB +: 4];
    assign osc_core_current_set_b = osc_cur[3:0];
    assign osc_core_current       = sel_b ? osc_cur[3:0] : osc_cur[CUR_A_LSB +: 4];

    // ----------------------------------------------------------------
    // Dividers
    // ----------------------------------------------------------------
    // Reference divide: code+1 crystal cycles; code 0 behaves as code 1
    function automatic logic [3:0] ref_ratio(input logic [2:0] code);
        ref_ratio = (code == 3'h0) ? 4'h2 : {1'b0, code} + 4'h1;
    endfunction

    // Modem divide in half cycles of the reference: div1 x 2 shifted left by the div2 code
    function automatic logic [ACC_W-1:0] half_ratio(input logic [7:0] c);
        half_ratio = ACC_W'({4'h0, HALF_DIV1[c[DIV1_LSB +: 3]]} << c[1:0]);
    endfunction

    logic [3:0]       ref_cnt;
    logic [ACC_W-1:0] mod_cnt;
    logic [2:0]       baud_cnt;
    logic [3:0]       ref_div;
    logic [ACC_W-1:0] mod_half;

    assign ref_div  = ref_ratio(clk_act[REF_DIV_LSB +: 3]);
    assign mod_half = half_ratio(clk_act);

    // Reference enable: one clk cycle in ref_div
    always_ff @(posedge clk) begin
        if (!nrst || ref_cnt >= ref_div - 4'h1) begin
            ref_cnt <= 4'h0;
        end else begin
            ref_cnt <= ref_cnt + 4'h1;
        end
    end
    assign reference_frequency = (ref_cnt == 4'h0);

    // modem clock from reference
    // Counts two per reference tick so the .5 ratios stay exact on average
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mod_cnt <= '0;
        end else if (reference_frequency) begin
            if (mod_cnt + ACC_W'(2) >= mod_half) begin
                mod_cnt <= mod_cnt + ACC_W'(2) - mod_half;
            end else begin
                mod_cnt <= mod_cnt + ACC_W'(2);
            end
        end
    end
    assign modem_clk_en = reference_frequency && (mod_cnt + ACC_W'(2) >= mod_half);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            baud_cnt <= 3'h0;
        end else if (modem_clk_en) begin
            baud_cnt <= baud_cnt + 3'h1;
        end
    end
    assign baud_en = modem_clk_en && (baud_cnt == 3'(BAUD_DIV - 1));

    // ----------------------------------------------------------------
    // Scrambler and data format
    // ----------------------------------------------------------------
    logic [PN_LEN-1:0] pn;
    logic              scr_bit;
    logic              half_sym;
    logic              data_clock_out_q;

    // scrambler sequence, one step per symbol
    always_ff @(posedge clk) begin
        if (!nrst || !modem[SCRAMBLE_BIT]) begin
            pn <= PN_SEED;
        end else if (baud_en) begin
            pn <= {pn[PN_LEN-2:0], pn[PN_LEN-1] ^ pn[PN_TAP-1]};
        end
    end
    assign scr_bit = modem[SCRAMBLE_BIT] ? (tx_bit ^ pn[PN_LEN-1]) : tx_bit;

    // Symbol phase toggles at mid-symbol for Manchester
    always_ff @(posedge clk) begin
        if (!nrst || baud_en) begin
            half_sym <= 1'b0;
        end else if (modem_clk_en && baud_cnt == 3'(BAUD_DIV / 2 - 1)) begin
            half_sym <= 1'b1;
        end
    end

    // format selection on output data and data clock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_data <= 1'b0;
            data_clock_out_q  <= 1'b0;
        end else begin
            case (modem[1:0])
                FMT_NRZ: begin
                    tx_data <= scr_bit;
                    data_clock_out_q  <= half_sym;
                end
                FMT_MANCH: begin
                    tx_data <= scr_bit ^ half_sym;
                    data_clock_out_q  <= half_sym;
                end
                FMT_UART0: begin
                    tx_data <= tx_bit;
                    data_clock_out_q  <= 1'b0;
                end
                FMT_UART1: begin
                    tx_data <= tx_bit;
                    data_clock_out_q  <= 1'b1;
                end
                default: begin
                    tx_data <= tx_bit;
                    data_clock_out_q  <= 1'b0;
                end
            endcase
        end
    end
    assign data_clock_out = data_clock_out_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Own count of modem ticks since the last symbol tick, kept apart from
    // baud_cnt so that a slip in the symbol divider cannot hide behind itself
    logic [3:0] chk_mod_ticks;
    always_ff @(posedge clk) begin
        if (!nrst || baud_en) begin
            chk_mod_ticks <= 4'h0;
        end else if (modem_clk_en) begin
            chk_mod_ticks <= chk_mod_ticks + 4'h1;
        end
    end

    // Register writes, reads, defaults and set selection
    word_b_sel_a: assert property (sel_b
        |-> freq_word_active == {fb_hi, fb_mid, fb_lo[7:1]})
        else $error("word B not assembled");
    mid_write_a: assert property (wr && addr == ADDR_FREQ_WORD_SET_B_MID && !soft_rst
        |=> fb_mid == $past(wdata))
        else $error("word B middle byte write lost");
    hi_read_a: assert property (rd && addr == ADDR_FREQ_WORD_SET_B_HI |=> rdata == $past(fb_hi))
        else $error("word B high byte read wrong");
    soft_rst_a: assert property (soft_rst
        |=> fb_hi == RST_FREQ_WORD_SET_B_HI && fb_lo == RST_FREQ_WORD_SET_B_LO)
        else $error("soft reset missed defaults");
    setb_dflt_a: assert property (soft_rst
        |=> clk_b == RST_CLOCK && osc_cur == RST_OSC_CUR)
        else $error("set B dividers missed defaults");
    main_keep_a: assert property (wr && addr == ADDR_MAIN_CTRL
        |=> main_ctrl == $past(wdata))
        else $error("control register not written directly");
    spare_zero_a: assert property (modem[7:3] == 5'h00)
        else $error("spare bits set");
    dither_enable_set_b_a: assert property (sel_b |-> dither_active == fb_lo[0])
        else $error("dither_enable_set_b not selected");
    cur_sel_a: assert property (!sel_b |-> osc_core_current == osc_cur[7:4])
        else $error("current A not selected");
    cur_b_a: assert property (sel_b |-> osc_core_current == osc_core_current_set_b)
        else $error("current B not selected");

    // Dividers; the reference period checks use the slowest code, which has most room to slip
    ref_period_a: assert property (reference_frequency && ref_div == 4'h8
        ##1 (ref_div == 4'h8) [*7] |=> reference_frequency)
        else $error("reference period wrong");
    ref_quiet_a: assert property (reference_frequency && ref_div == 4'h8
        |=> (!reference_frequency || ref_div != 4'h8) [*7])
        else $error("reference tick too early");
    ref_gap_a: assert property (reference_frequency |=> !reference_frequency)
        else $error("reference enable too long");
    modem_ref_a: assert property (modem_clk_en |-> reference_frequency)
        else $error("modem tick without reference");
    baud_mod_a: assert property (baud_en |-> modem_clk_en)
        else $error("baud without modem tick");
    baud_tick_a: assert property (modem_clk_en
        |-> baud_en == (chk_mod_ticks == 4'(BAUD_DIV - 1)))
        else $error("symbol tick not on eighth modem tick");

    // Scrambler and data format
    scr_off_a: assert property (!modem[SCRAMBLE_BIT] |-> scr_bit == tx_bit)
        else $error("scrambler active when off");
    pn_seed_a: assert property (!modem[SCRAMBLE_BIT] |=> pn == PN_SEED)
        else $error("scrambler not reseeded while off");
    pn_hold_a: assert property (modem[SCRAMBLE_BIT] && !baud_en |=> $stable(pn))
        else $error("scrambler stepped between symbols");
    uart_data_clock_out_a: assert property (modem[1:0] == FMT_UART1 |=> data_clock_out)
        else $error("data clock not held high");
    uart_low_a: assert property (modem[1:0] == FMT_UART0 |=> !data_clock_out)
        else $error("data clock not held low");
    uart_pass_a: assert property (modem[1:0] == FMT_UART0 || modem[1:0] == FMT_UART1
        |=> tx_data == $past(tx_bit))
        else $error("transparent data not passed");

    baud_c: cover property (baud_en);
    setb_c: cover property (sel_b && modem_clk_en);
    manch_c: cover property (modem[1:0] == FMT_MANCH && baud_en);
    uart_c: cover property (modem[1:0] == FMT_UART1 && data_clock_out);
    scram_c: cover property (modem[SCRAMBLE_BIT] && baud_en);
endmodule
`default_nettype wire

/* bench/mcfb_host.sv */
// Host model that drives the register port of the bank
`timescale 1ns/1ps
`default_nettype none
module mcfb_host
    import mcfb_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Register port towards the bank
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    // ----------------------------------------
    // Bus cycles, each launched after a rising edge
    // ----------------------------------------
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One write cycle; back to back calls give gapless strobes
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == ADDR_MODEM) begin
            v = d & MODEM_WMASK;
        end
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // One read cycle; data is taken by the bench monitor
    task automatic read(input logic [7:0] a);
        addr <= a;
        wdata <= ~wdata;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    // Idle: no strobe, and stale address and data are scrambled
    task automatic idle();
        addr <= ~addr;
        wdata <= ~wdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* bench/mcfb_bank_test.sv */
// Self-checking bench for the clock and frequency register bank
`timescale 1ns/1ps
`default_nettype none
module mcfb_bank_test;
    import mcfb_pkg::*;
    logic        clk, nrst, tx_bit, dither_enable_set_a, rd_q, last_bit;
    logic [22:0] freq_word_set_a;
    logic [7:0]  addr, wdata, rdata;
    logic        wr, rd, tx_data, dither_active, data_clock_out;
    logic [22:0] freq_word_active;
    logic [3:0]  osc_core_current, osc_core_current_set_a, osc_core_current_set_b;
    logic        reference_frequency, modem_clk_en, baud_en;
    int          error_cnt, num_checks, cyc, cnt, ones;
    int          seed = 32'h0e5ed540;
    logic [7:0]  v [7:13];
    logic [7:0]  dflt [8] = '{8'h50, 8'h83, 8'hbd, 8'hf9, 8'h50, 8'h88, 8'h00, 8'h01};
    int          half [8] = '{5, 6, 8, 15, 25, 80, 96, 128};
    logic [7:0]  exp_q [$];

    mcfb_bank #(.ACC_W(12)) i_mcfb_bank (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .freq_word_set_a(freq_word_set_a),
        .dither_enable_set_a(dither_enable_set_a), .tx_bit(tx_bit), .tx_data(tx_data),
        .freq_word_active(freq_word_active), .dither_active(dither_active),
        .osc_core_current(osc_core_current), .osc_core_current_set_a(osc_core_current_set_a),
        .osc_core_current_set_b(osc_core_current_set_b),
        .reference_frequency(reference_frequency), .modem_clk_en(modem_clk_en),
        .baud_en(baud_en), .data_clock_out(data_clock_out));
    mcfb_host i_mcfb_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_mcfb_host.read(a);
    endtask
    task automatic wr1(input logic [7:0] a, input logic [7:0] d);
        // Align to a rising edge so a strobe never launches from a falling one
        @(posedge clk);
        i_mcfb_host.write(a, d);
        i_mcfb_host.idle();
    endtask
    function automatic logic ev(input int s);
        case (s)
            0: ev = 1'b1;
            1: ev = reference_frequency;
            2: ev = modem_clk_en;
            default: ev = baud_en;
        endcase
    endfunction
    // Counts fast events over n slow periods; two slow events resync after a change
    task automatic measure(input int f, input int s, input int n, output int c);
        int k;
        k = 0;
        c = 0;
        while (k < n + 2) begin
            @(negedge clk);
            if (k >= 2 && ev(f)) c++;
            if (ev(s)) k++;
        end
    endtask
    task wrap_up;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, timeout and read monitor
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // Read data stands only in the cycle after the strobe
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk) begin
        if (rd_q === 1'b1 && exp_q.size() > 0) check(rdata, exp_q.pop_front());
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        tx_bit = 1'b0;
        freq_word_set_a = 23'($random(seed));
        dither_enable_set_a = 1'($random(seed));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rd_exp(8'(7 + i), dflt[i]);
        end
        rd_exp(8'h00, 8'h00);
        // Random values written and read back with no gap
        for (int a = 7; a < 14; a++) begin
            v[a] = 8'($random(seed));
            i_mcfb_host.write(8'(a), v[a]);
        end
        v[13] = v[13] & 8'h07;
        for (int a = 7; a < 14; a++) begin
            rd_exp(8'(a), v[a]);
        end
        i_mcfb_host.idle();
        @(negedge clk);
        check(freq_word_active, freq_word_set_a);
        check(dither_active, dither_enable_set_a);
        check(osc_core_current, v[12][7:4]);
        check(osc_core_current_set_b, v[12][3:0]);
        wr1(ADDR_MAIN_CTRL, 8'h41);
        @(negedge clk);
        check(freq_word_active, {v[8], v[9], v[10][7:1]});
        check(dither_active, v[10][0]);
        check(osc_core_current, v[12][3:0]);
        // Soft reset restores the bank but not the control register
        wr1(ADDR_MAIN_CTRL, 8'h40);
        wr1(ADDR_MAIN_CTRL, 8'h41);
        for (int i = 0; i < 7; i++) begin
            rd_exp(8'(7 + i), dflt[i]);
        end
        rd_exp(ADDR_MAIN_CTRL, 8'h41);
        i_mcfb_host.idle();
        @(negedge clk);
        check(freq_word_active, {8'd131, 8'd189, 7'd124});
        wr1(ADDR_CLOCK_B, 8'h20);
        measure(0, 1, 1, cnt);
        check(cnt, 2);
        measure(1, 2, 2, cnt);
        check(cnt, 5);
        measure(2, 3, 1, cnt);
        check(cnt, 8);
        wr1(ADDR_MAIN_CTRL, 8'h01);
        for (int c = 1; c < 8; c++) begin
            wr1(ADDR_CLOCK_A, 8'(c << 5));
            measure(0, 1, 1, cnt);
            check(cnt, c + 1);
        end
        // Two modem periods span the whole half-step ratio
        for (int d = 0; d < 12; d++) begin
            wr1(ADDR_CLOCK_A, (d < 8) ? 8'(8'h20 | (d << 2)) : 8'(8'h2c | (d - 8)));
            measure(1, 2, 2, cnt);
            check(cnt, (d < 8) ? half[d] : 15 << (d - 8));
        end
        wr1(ADDR_CLOCK_A, 8'h20);
        for (int f = 2; f < 4; f++) begin
            wr1(ADDR_MODEM, 8'(f));
            repeat (50) begin
                @(posedge clk);
                // Bit taken by the bank at this edge; it shows on the data output after it
                last_bit = tx_bit;
                tx_bit <= 1'($random(seed));
                @(negedge clk);
                check(data_clock_out, f[0]);
                check(tx_data, last_bit);
            end
        end
        // Constant zero data must stay flat unless scrambled or Manchester coded
        for (int s = 0; s < 3; s++) begin
            wr1(ADDR_MODEM, (s == 2) ? 8'(FMT_MANCH) : 8'(s << 2));
            tx_bit <= 1'b0;
            ones = 0;
            repeat (80) @(posedge clk);
            repeat (400) begin
                @(negedge clk);
                ones += int'(tx_data === 1'b1);
            end
            check(ones != 0, s != 0);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
